// ---- hdl/ussr_top.sv ----
// Design decisions made here: the address-and-strobe port and the register offsets.
`timescale 1ns/1ns
module ussr_top import ussr_pkg::*; (
  input wire logic REF_CLK,
  input wire logic RSTN,
  input wire logic [3:0] ADDR,
  input wire logic [7:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [7:0] RDATA,
  input wire logic SER_CLK,
  input wire logic SER_DATA,
  input wire logic POWER_SAVE,
  output logic IRQ,
  output logic WAKE
);
  logic [7:0] rx_status_control_reg;
  logic [7:0] rx_buffer_reg;
  logic [7:0] tx_status_control_reg;
  logic [7:0] baud_divisor_reg;
  logic [7:0] peripheral_flags_one_reg;
  logic [7:0] peripheral_enables_one_reg;
  logic buffer_full_reg;
  logic sclk_s;
  logic sdata_s;
  logic sclk_prev_reg;
  logic sclk_rise;
  logic run;
  logic done;
  logic [8:0] word;
  logic wr_rcs;
  logic rd_buf;
  logic continuous_receive_enable_next;

  function automatic logic hit(input logic [3:0] a, input logic [3:0] target);
    hit = (a == target);
  endfunction

  ussr_sync2 u_sync_clk (
    .clk(REF_CLK),
    .rst_n(RSTN),
    .d(SER_CLK),
    .q(sclk_s)
  );
  ussr_sync2 u_sync_data (
    .clk(REF_CLK),
    .rst_n(RSTN),
    .d(SER_DATA),
    .q(sdata_s)
  );

  always_ff @(posedge REF_CLK or negedge RSTN) begin
    if (!RSTN) begin
      sclk_prev_reg <= 1'b0;
    end else begin
      sclk_prev_reg <= sclk_s;
    end
  end
  // Data sampled on the master's rising edge, both paths equally delayed
  assign sclk_rise = sclk_s && !sclk_prev_reg;

  // Runs regardless of power state and single receive
  assign run = rx_status_control_reg[RCS_SERIAL_PORT_ENABLE]
            && rx_status_control_reg[RCS_CONTINUOUS_RECEIVE_ENABLE]
            && tx_status_control_reg[TXS_SYNC_MODE]
            && !tx_status_control_reg[TXS_CLOCK_SOURCE_SELECT];

  ussr_shifter u_shift (
    .clk(REF_CLK),
    .rst_n(RSTN),
    .run(run),
    .nine(rx_status_control_reg[RCS_NINE_BIT_RECEIVE]),
    .sclk_rise(sclk_rise),
    .sdata(sdata_s),
    .done(done),
    .word(word)
  );

  assign wr_rcs = WR && hit(ADDR, ADDR_RX_STATUS_CONTROL);
  assign rd_buf = RD && hit(ADDR, ADDR_RX_BUFFER);
  assign continuous_receive_enable_next = wr_rcs ? WDATA[RCS_CONTINUOUS_RECEIVE_ENABLE]
                            : rx_status_control_reg[RCS_CONTINUOUS_RECEIVE_ENABLE];

  // Status/control: software bits plus hardware-owned ninth bit and errors
  always_ff @(posedge REF_CLK or negedge RSTN) begin
    if (!RSTN) begin
      rx_status_control_reg <= RX_STATUS_CONTROL_RESET;
    end else begin
      if (wr_rcs) begin
        rx_status_control_reg[7:3] <= WDATA[7:3];
      end
      if (!continuous_receive_enable_next) begin
        rx_status_control_reg[RCS_OVERRUN_ERROR_FLAG] <= 1'b0;
        rx_status_control_reg[RCS_FRAMING_ERROR_FLAG] <= 1'b0;
      end else if (done && buffer_full_reg && !rd_buf) begin
        rx_status_control_reg[RCS_OVERRUN_ERROR_FLAG] <= 1'b1;
      end
      if (done && !(buffer_full_reg && !rd_buf)) begin
        rx_status_control_reg[RCS_NINTH_RECEIVED_BIT] <=
          rx_status_control_reg[RCS_NINE_BIT_RECEIVE] & word[8];
        // No stop bit in sync mode, so a framing error never arises here
        rx_status_control_reg[RCS_FRAMING_ERROR_FLAG] <= 1'b0;
      end
    end
  end

  // Buffer load; the unread word is kept on overrun
  always_ff @(posedge REF_CLK or negedge RSTN) begin
    if (!RSTN) begin
      rx_buffer_reg <= RX_BUFFER_RESET;
      buffer_full_reg <= 1'b0;
    end else begin
      if (done && !(buffer_full_reg && !rd_buf)) begin
        rx_buffer_reg <= word[7:0];
        buffer_full_reg <= 1'b1;
      end else if (rd_buf) begin
        buffer_full_reg <= 1'b0;
      end
    end
  end

  // Receive flag set by each word, cleared by a buffer read or a write of 1; set beats clear
  always_ff @(posedge REF_CLK or negedge RSTN) begin
    if (!RSTN) begin
      peripheral_flags_one_reg <= PERIPHERAL_FLAGS_ONE_RESET;
    end else begin
      if (WR && hit(ADDR, ADDR_PERIPHERAL_FLAGS_ONE)) begin
        peripheral_flags_one_reg <= peripheral_flags_one_reg & ~WDATA;
      end
      if (done) begin
        peripheral_flags_one_reg[PF_RECEIVE] <= 1'b1;
      end else if (rd_buf) begin
        peripheral_flags_one_reg[PF_RECEIVE] <= 1'b0;
      end
    end
  end

  always_ff @(posedge REF_CLK or negedge RSTN) begin
    if (!RSTN) begin
      tx_status_control_reg <= TX_STATUS_CONTROL_RESET;
      baud_divisor_reg <= BAUD_DIVISOR_RESET;
      peripheral_enables_one_reg <= PERIPHERAL_ENABLES_ONE_RESET;
    end else if (WR) begin
      if (hit(ADDR, ADDR_TX_STATUS_CONTROL)) begin
        tx_status_control_reg <= (WDATA & TXS_WRITE_MASK) | TX_STATUS_CONTROL_RESET;
      end
      if (hit(ADDR, ADDR_BAUD_DIVISOR)) begin
        baud_divisor_reg <= WDATA;
      end
      if (hit(ADDR, ADDR_PERIPHERAL_ENABLES_ONE)) begin
        peripheral_enables_one_reg <= WDATA;
      end
    end
  end

  always_ff @(posedge REF_CLK or negedge RSTN) begin
    if (!RSTN) begin
      IRQ <= 1'b0;
      WAKE <= 1'b0;
    end else begin
      IRQ <= |(peripheral_flags_one_reg & peripheral_enables_one_reg);
      WAKE <= POWER_SAVE && peripheral_flags_one_reg[PF_RECEIVE]
           && peripheral_enables_one_reg[PF_RECEIVE];
    end
  end

  always_ff @(posedge REF_CLK or negedge RSTN) begin
    if (!RSTN) begin
      RDATA <= 8'h00;
    end else if (RD) begin
      case (ADDR)
        ADDR_RX_STATUS_CONTROL: RDATA <= rx_status_control_reg;
        ADDR_RX_BUFFER: RDATA <= rx_buffer_reg;
        ADDR_TX_STATUS_CONTROL: RDATA <= tx_status_control_reg;
        ADDR_BAUD_DIVISOR: RDATA <= baud_divisor_reg;
        ADDR_PERIPHERAL_FLAGS_ONE: RDATA <= peripheral_flags_one_reg;
        ADDR_PERIPHERAL_ENABLES_ONE: RDATA <= peripheral_enables_one_reg;
        default: RDATA <= 8'h00;
      endcase
    end else begin
      RDATA <= 8'h00;
    end
  end

  AST_NO_RUN_NO_DONE: assert property (@(posedge REF_CLK) disable iff (!RSTN)
    !run |=> !done) else $error("word completed while receiver disabled");
  AST_SINGLE_RECEIVE_ENABLE_IGNORED: assert property (@(posedge REF_CLK) disable iff (!RSTN)
    (rx_status_control_reg[RCS_SERIAL_PORT_ENABLE]
     && rx_status_control_reg[RCS_CONTINUOUS_RECEIVE_ENABLE]
     && tx_status_control_reg[TXS_SYNC_MODE]
     && !tx_status_control_reg[TXS_CLOCK_SOURCE_SELECT]) |-> run)
    else $error("run depends on single receive");
  AST_POWER_SAVE_RUNS: assert property (@(posedge REF_CLK) disable iff (!RSTN)
    (POWER_SAVE && done && !buffer_full_reg) |=> buffer_full_reg)
    else $error("word lost in power save");
  AST_LOAD_BUFFER: assert property (@(posedge REF_CLK) disable iff (!RSTN)
    (done && !buffer_full_reg) |=> rx_buffer_reg == $past(word[7:0]))
    else $error("buffer not loaded");
  AST_FLAG_SET: assert property (@(posedge REF_CLK) disable iff (!RSTN)
    done |=> peripheral_flags_one_reg[PF_RECEIVE])
    else $error("receive flag not set");
  AST_IRQ_LEVEL: assert property (@(posedge REF_CLK) disable iff (!RSTN)
    (peripheral_flags_one_reg[PF_RECEIVE] && peripheral_enables_one_reg[PF_RECEIVE])
    |=> IRQ) else $error("irq missing");
  AST_WAKE: assert property (@(posedge REF_CLK) disable iff (!RSTN)
    (POWER_SAVE && peripheral_flags_one_reg[PF_RECEIVE]
     && peripheral_enables_one_reg[PF_RECEIVE]) |=> WAKE)
    else $error("no wake");
  AST_CLEAR_ERR: assert property (@(posedge REF_CLK) disable iff (!RSTN)
    !rx_status_control_reg[RCS_CONTINUOUS_RECEIVE_ENABLE]
    |-> !rx_status_control_reg[RCS_OVERRUN_ERROR_FLAG])
    else $error("error kept with receive off");
  AST_OVERRUN: assert property (@(posedge REF_CLK) disable iff (!RSTN)
    (done && buffer_full_reg && !rd_buf && continuous_receive_enable_next) |=>
    (rx_status_control_reg[RCS_OVERRUN_ERROR_FLAG] && $stable(rx_buffer_reg)))
    else $error("overrun not flagged");
  AST_NINTH_EIGHT: assert property (@(posedge REF_CLK) disable iff (!RSTN)
    (done && !buffer_full_reg && !rx_status_control_reg[RCS_NINE_BIT_RECEIVE]) |=>
    !rx_status_control_reg[RCS_NINTH_RECEIVED_BIT])
    else $error("ninth bit set in 8-bit mode");
  AST_NINTH_NINE: assert property (@(posedge REF_CLK) disable iff (!RSTN)
    (done && !buffer_full_reg && rx_status_control_reg[RCS_NINE_BIT_RECEIVE]) |=>
    rx_status_control_reg[RCS_NINTH_RECEIVED_BIT] == $past(word[8]))
    else $error("ninth bit not kept in 9-bit mode");
  AST_IRQ_OFF: assert property (@(posedge REF_CLK) disable iff (!RSTN)
    !(|(peripheral_flags_one_reg & peripheral_enables_one_reg)) |=> !IRQ)
    else $error("irq without unmasked flag");
  AST_RDATA_IDLE: assert property (@(posedge REF_CLK) disable iff (!RSTN)
    !RD |=> RDATA == 8'h00)
    else $error("read data outside read cycle");
endmodule

// ---- pkg/ussr_pkg.sv ----
package ussr_pkg;
  localparam int ADDR_W = 4;
  localparam logic [3:0] ADDR_RX_STATUS_CONTROL = 4'h0;
  localparam logic [3:0] ADDR_RX_BUFFER = 4'h1;
  localparam logic [3:0] ADDR_TX_STATUS_CONTROL = 4'h2;
  localparam logic [3:0] ADDR_BAUD_DIVISOR = 4'h3;
  localparam logic [3:0] ADDR_PERIPHERAL_FLAGS_ONE = 4'h4;
  localparam logic [3:0] ADDR_PERIPHERAL_ENABLES_ONE = 4'h5;
  localparam logic [3:0] ADDR_POWER_STATE = 4'h6;
  // rx_status_control fields
  localparam int RCS_SERIAL_PORT_ENABLE = 7;
  localparam int RCS_NINE_BIT_RECEIVE = 6;
  localparam int RCS_SINGLE_RECEIVE_ENABLE = 5;
  localparam int RCS_CONTINUOUS_RECEIVE_ENABLE = 4;
  localparam int RCS_ADDRESS_DETECT = 3;
  localparam int RCS_FRAMING_ERROR_FLAG = 2;
  localparam int RCS_OVERRUN_ERROR_FLAG = 1;
  localparam int RCS_NINTH_RECEIVED_BIT = 0;
  // tx_status_control fields
  localparam int TXS_CLOCK_SOURCE_SELECT = 7;
  localparam int TXS_SYNC_MODE = 4;
  // peripheral flag / enable position
  localparam int PF_RECEIVE = 5;
  localparam logic [7:0] RX_STATUS_CONTROL_RESET = 8'h00;
  localparam logic [7:0] RX_BUFFER_RESET = 8'h00;
  localparam logic [7:0] TX_STATUS_CONTROL_RESET = 8'h02;
  localparam logic [7:0] BAUD_DIVISOR_RESET = 8'h00;
  localparam logic [7:0] PERIPHERAL_FLAGS_ONE_RESET = 8'h00;
  localparam logic [7:0] PERIPHERAL_ENABLES_ONE_RESET = 8'h00;
  localparam logic [3:0] BITS_EIGHT = 4'h8;
  localparam logic [3:0] BITS_NINE = 4'h9;
  // Mask of writable bits in tx_status_control (bit 3 unimplemented, bit 1 idle-high status)
  localparam logic [7:0] TXS_WRITE_MASK = 8'hF5;
  localparam logic [7:0] RCS_WRITE_MASK = 8'hF8;
endpackage

// ---- hdl/ussr_sync2.sv ----
`timescale 1ns/1ns
module ussr_sync2 import ussr_pkg::*; (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic d,
  output logic q
);
  logic meta_reg;
  // First stage feeds only the second
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_reg <= 1'b0;
      q <= 1'b0;
    end else begin
      meta_reg <= d;
      q <= meta_reg;
    end
  end
endmodule

// ---- hdl/ussr_shifter.sv ----
`timescale 1ns/1ns
module ussr_shifter import ussr_pkg::*; (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic run,
  input wire logic nine,
  input wire logic sclk_rise,
  input wire logic sdata,
  output logic done,
  output logic [8:0] word
);
  logic [8:0] receive_shift_reg;
  logic [3:0] cnt_reg;
  logic [3:0] last_w;
  logic [8:0] shifted_w;
  assign last_w = nine ? BITS_NINE : BITS_EIGHT;
  // LSB first; an 8-bit word ends up in the low bits
  assign shifted_w = nine ? {sdata, receive_shift_reg[8:1]} :
                            {1'b0, sdata, receive_shift_reg[7:1]};
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      receive_shift_reg <= 9'h000;
      cnt_reg <= 4'h0;
      done <= 1'b0;
      word <= 9'h000;
    end else begin
      done <= 1'b0;
      if (!run) begin
        cnt_reg <= 4'h0;
      end else if (sclk_rise) begin
        receive_shift_reg <= shifted_w;
        if (cnt_reg + 4'h1 == last_w) begin
          cnt_reg <= 4'h0;
          done <= 1'b1;
          word <= shifted_w;
        end else begin
          cnt_reg <= cnt_reg + 4'h1;
        end
      end
    end
  end
endmodule

// ---- sim/ussr_master_model.sv ----
`timescale 1ns/1ns
module ussr_master_model (
  input wire logic clk,
  output logic ser_clk,
  output logic ser_data
);
  initial begin
    ser_clk = 1'b0;
    ser_data = 1'b0;
  end

  // Clock rests low between words; released data shows the inverse of the last bit
  task automatic send(input logic [8:0] word, input logic nine, input int half);
    int nbits;
    nbits = nine ? 9 : 8;
    for (int i = 0; i < nbits; i++) begin
      @(posedge clk);
      ser_data <= word[i];
      repeat (half) @(posedge clk);
      ser_clk <= 1'b1;
      repeat (half) @(posedge clk);
      ser_clk <= 1'b0;
    end
    @(posedge clk);
    ser_data <= ~word[nbits-1];
  endtask
endmodule

// ---- sim/usart_sync_slave_receiver_test.sv ----
`timescale 1ns/1ns
module usart_sync_slave_receiver_test;
  import ussr_pkg::*;
  typedef struct packed {logic [7:0] ctl; logic [8:0] word; logic ps;} ussr_row_t;
  logic ref_clk = 1'b0;
  logic rstn, wr, rd, ser_clk, ser_data, power_save, irq, wake;
  logic [3:0] addr;
  logic [7:0] wdata, rdata;
  int errors = 0;
  int n_checks = 0;
  int cycles = 0;
  // Rows mix single receive on and off; it must change nothing
  ussr_row_t rows [4] = '{'{8'h90, 9'h0A5, 1'b0}, '{8'hB0, 9'h03C, 1'b1},
                          '{8'hD0, 9'h1FF, 1'b0}, '{8'hF0, 9'h055, 1'b1}};
  logic [7:0] rst_exp [7] = '{8'h00, 8'h00, 8'h02, 8'h00, 8'h00, 8'h00, 8'h00};

  always #5 ref_clk = ~ref_clk;

  ussr_top u_dut (.REF_CLK(ref_clk), .RSTN(rstn), .ADDR(addr), .WDATA(wdata), .WR(wr),
    .RD(rd), .RDATA(rdata), .SER_CLK(ser_clk), .SER_DATA(ser_data),
    .POWER_SAVE(power_save), .IRQ(irq), .WAKE(wake));
  ussr_master_model u_master (.clk(ref_clk), .ser_clk(ser_clk), .ser_data(ser_data));

  task report_and_stop;
    if (errors == 0 && n_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task automatic check8(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t: byte %h, expected %h", $time, got, exp);
    end
  endtask

  task automatic check1(input logic got, input logic exp);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t: bit %b, expected %b", $time, got, exp);
    end
  endtask

  task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge ref_clk);
    wr <= 1'b0;
  endtask

  // Read data stands only in the cycle after the strobe
  task automatic rd_chk(input logic [3:0] a, input logic [7:0] exp);
    @(posedge ref_clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge ref_clk);
    rd <= 1'b0;
    @(negedge ref_clk);
    check8(rdata, exp);
  endtask

  // Bounded wait; also serves as a quiet window when no interrupt is due
  task automatic wait_irq;
    for (int i = 0; i < 100 && irq !== 1'b1; i++) @(negedge ref_clk);
  endtask

  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 30000) begin
      errors++;
      report_and_stop();
    end
  end

  initial begin
    rstn = 1'b0;
    wr = 1'b0;
    rd = 1'b0;
    addr = 4'h0;
    wdata = 8'h00;
    power_save = 1'b0;
    repeat (4) @(posedge ref_clk);
    rstn <= 1'b1;
    wr_reg(ADDR_TX_STATUS_CONTROL, 8'h10);
    wr_reg(ADDR_PERIPHERAL_ENABLES_ONE, 8'h20);
    foreach (rows[k]) begin
      wr_reg(ADDR_RX_STATUS_CONTROL, rows[k].ctl);
      power_save <= rows[k].ps;
      u_master.send(rows[k].word, rows[k].ctl[RCS_NINE_BIT_RECEIVE], 8);
      wait_irq();
      check1(irq, 1'b1);
      check1(wake, rows[k].ps);
      rd_chk(ADDR_RX_STATUS_CONTROL, rows[k].ctl |
        {7'h00, rows[k].ctl[RCS_NINE_BIT_RECEIVE] & rows[k].word[8]});
      rd_chk(ADDR_RX_BUFFER, rows[k].word[7:0]);
      rd_chk(ADDR_PERIPHERAL_FLAGS_ONE, 8'h00);
      check1(irq, 1'b0);
      power_save <= 1'b0;
    end
    // Second reset in mid-run, then reset values and access kinds
    rstn <= 1'b0;
    repeat (4) @(posedge ref_clk);
    rstn <= 1'b1;
    for (int a = 0; a < 7; a++) rd_chk(4'(a), rst_exp[a]);
    wr_reg(ADDR_BAUD_DIVISOR, 8'h5A);
    rd_chk(ADDR_BAUD_DIVISOR, 8'h5A);
    wr_reg(ADDR_RX_BUFFER, 8'hFF);
    rd_chk(ADDR_RX_BUFFER, 8'h00);
    wr_reg(ADDR_POWER_STATE, 8'hFF);
    rd_chk(ADDR_POWER_STATE, 8'h00);
    wr_reg(ADDR_TX_STATUS_CONTROL, 8'hFF);
    rd_chk(ADDR_TX_STATUS_CONTROL, 8'hF7);
    wr_reg(ADDR_RX_STATUS_CONTROL, 8'hFF);
    rd_chk(ADDR_RX_STATUS_CONTROL, 8'hF8);
    // Without continuous receive nothing is taken
    wr_reg(ADDR_TX_STATUS_CONTROL, 8'h10);
    wr_reg(ADDR_RX_STATUS_CONTROL, 8'h80);
    wr_reg(ADDR_PERIPHERAL_ENABLES_ONE, 8'h20);
    u_master.send(9'h0C3, 1'b0, 8);
    wait_irq();
    check1(irq, 1'b0);
    rd_chk(ADDR_PERIPHERAL_FLAGS_ONE, 8'h00);
    // Masked flag, then an unread buffer overrun from a slow master
    wr_reg(ADDR_PERIPHERAL_ENABLES_ONE, 8'h00);
    wr_reg(ADDR_RX_STATUS_CONTROL, 8'h90);
    u_master.send(9'h05A, 1'b0, 8);
    wait_irq();
    check1(irq, 1'b0);
    rd_chk(ADDR_PERIPHERAL_FLAGS_ONE, 8'h20);
    u_master.send(9'h033, 1'b0, 16);
    wait_irq();
    rd_chk(ADDR_RX_STATUS_CONTROL, 8'h92);
    wr_reg(ADDR_PERIPHERAL_FLAGS_ONE, 8'h20);
    rd_chk(ADDR_PERIPHERAL_FLAGS_ONE, 8'h00);
    rd_chk(ADDR_RX_BUFFER, 8'h5A);
    wr_reg(ADDR_RX_STATUS_CONTROL, 8'h80);
    rd_chk(ADDR_RX_STATUS_CONTROL, 8'h80);
    report_and_stop();
  end
endmodule
